// >>> channel_mode_steering.sv
//------------------------------------------------------------
//------------------------------------------------------------
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module channel_mode_steering
    import channel_mode_steering_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic [3:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    input wire logic ref_clock_in,
    input wire logic tx_clk_in,
    input wire pins_t pins_in,
    input wire logic [NCH*NIB_W-1:0] tx_nibble_bus_in,
    input wire logic [NCH-1:0] rx_serial_in,
    output logic [NCH-1:0] tx_serial_out,
    output logic [NCH*NIB_W-1:0] rx_nibble_bus_out,
    output logic [NCH-1:0] rx_clk_out,
    output logic sgmii_mode_out
);
    localparam int SYNC_W = 2 + $bits(pins_t) + NCH + NCH*NIB_W;

    //--------------------------------------------------------
    // input synchronisers
    //--------------------------------------------------------
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else if (ce_in) begin
            sync1_r <= {ref_clock_in, tx_clk_in, pins_in, rx_serial_in, tx_nibble_bus_in};
            sync2_r <= sync1_r;
        end
    end

    logic ref_s;
    logic tclk_s;
    pins_t pin_s;
    logic [NCH-1:0] rxs;
    logic [NCH*NIB_W-1:0] nib_s;
    assign {ref_s, tclk_s, pin_s, rxs, nib_s} = sync2_r;

    logic tclk_prev_r;
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tclk_prev_r <= 1'b0;
        end else if (ce_in) begin
            tclk_prev_r <= tclk_s;
        end
    end
    wire tclk_rise = tclk_s & ~tclk_prev_r;
    wire tclk_fall = ~tclk_s & tclk_prev_r;

    //--------------------------------------------------------
    // register bus
    //--------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [NCH-1:0] prbs_err_r;
    logic [NCH-1:0] locked_r;
    logic sgmii_r;
    logic [1:0] cap_cnt_r;
    bus_state_t bus_r;
    logic [NCH-1:0] pcs_eff;
    logic [NCH-1:0] rc_eff;

    function automatic logic [31:0] merge_be(input logic [31:0] old,
            input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    wire req = read_in | write_in;
    wire take = req & (bus_r == BUS_ACK);
    wire wr_ctrl = take & write_in & (address_in == ADDR_CTRL);
    wire wr_stat = take & write_in & (address_in == ADDR_STAT);

    // one wait cycle: answer lands on the second edge of a request
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bus_r <= BUS_IDLE;
            waitrequest_out <= 1'b1;
            readdata_out <= '0;
        end else if (ce_in) begin
            case (bus_r)
                BUS_IDLE: begin
                    if (req) begin
                        bus_r <= BUS_ACK;
                        waitrequest_out <= 1'b0;
                        if (address_in == ADDR_CTRL) begin
                            readdata_out <= ctrl_r;
                        end else if (address_in == ADDR_STAT) begin
                            readdata_out <= 32'h0000_0000
                                | (32'(prbs_err_r) << STAT_PRBS_LSB)
                                | (32'(locked_r) << STAT_LOCK_LSB)
                                | (32'(rc_eff) << STAT_RC_LSB)
                                | (32'(pcs_eff) << STAT_PCS_LSB);
                        end else begin
                            readdata_out <= '0;
                        end
                    end
                end
                BUS_ACK: begin
                    bus_r <= BUS_IDLE;
                    waitrequest_out <= 1'b1;
                end
                default: begin
                    bus_r <= BUS_IDLE;
                    waitrequest_out <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl_r <= CTRL_RST;
        end else if (ce_in) begin
            if (wr_ctrl) begin
                ctrl_r <= merge_be(ctrl_r, writedata_in, byteenable_in);
            end else begin
                ctrl_r[CTRL_SGMII_BIT] <= sgmii_r;
            end
        end
    end

    // sgmii default caught once the pin has crossed the synchroniser
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cap_cnt_r <= '0;
            sgmii_r <= 1'b0;
            sgmii_mode_out <= 1'b0;
        end else if (ce_in) begin
            if (cap_cnt_r != SGMII_CAPTURE) begin
                cap_cnt_r <= cap_cnt_r + 2'h1;
                if (cap_cnt_r == SGMII_CAPTURE - 2'h1) begin
                    sgmii_r <= pin_s.serial_gmii_pin;
                end
            end else if (wr_ctrl && byteenable_in[0]) begin
                sgmii_r <= writedata_in[CTRL_SGMII_BIT];
            end
            sgmii_mode_out <= sgmii_r;
        end
    end

    //--------------------------------------------------------
    // effective modes
    //--------------------------------------------------------
    logic [NCH-1:0] relay_eff;
    logic [NCH-1:0] xchg_eff;
    logic prbs_on;
    logic align_on;
    always_comb begin
        prbs_on = pin_s.prbs_test_enable_pin;
        align_on = pin_s.comma_align_enable & ctrl_r[CTRL_COMMA_BIT];
        for (int i = 0; i < NCH; i++) begin
            pcs_eff[i] = pin_s.pcs_select_pin & ctrl_r[CTRL_PCS_BIT]
                & ~ctrl_r[CTRL_PCSDIS_LSB + i];
            rc_eff[i] = pin_s.rate_comp_enable & ctrl_r[CTRL_RC_BIT]
                & pcs_eff[i];
            relay_eff[i] = ctrl_r[CTRL_RELAY_LSB + i]
                | ((i % 2 == 0) ? pin_s.relay_to_ace_pin
                                : pin_s.relay_to_bdf_pin);
            xchg_eff[i] = pin_s.port_exchange_pin
                | ctrl_r[CTRL_XCHG_LSB + i/2];
        end
    end

    //--------------------------------------------------------
    // parallel capture, both link clock edges
    //--------------------------------------------------------
    logic [NIB_W-1:0] lo_r [NCH];
    logic [WORD_W-1:0] par_r [NCH];
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < NCH; i++) begin
                lo_r[i] <= '0;
                par_r[i] <= '0;
            end
        end else if (ce_in) begin
            for (int i = 0; i < NCH; i++) begin
                if (tclk_rise) begin
                    lo_r[i] <= nib_s[i*NIB_W +: NIB_W];
                end
                if (tclk_fall) begin
                    par_r[i] <= {nib_s[i*NIB_W +: NIB_W], lo_r[i]};
                end
            end
        end
    end

    //--------------------------------------------------------
    // prbs generator, shared by all channels
    //--------------------------------------------------------
    logic [6:0] gen_r;
    wire gen_bit = gen_r[6] ^ gen_r[5];
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            gen_r <= PRBS_SEED;
        end else if (ce_in && prbs_on) begin
            gen_r <= {gen_r[5:0], gen_bit};
        end
    end

    //--------------------------------------------------------
    // receive: alignment, checker
    //--------------------------------------------------------
    logic [WORD_W-1:0] rsh_r [NCH];
    logic [WORD_W-1:0] rword_r [NCH];
    logic [3:0] rcnt_r [NCH];
    logic [6:0] chk_r [NCH];
    logic [2:0] fill_r [NCH];
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            locked_r <= '0;
            for (int i = 0; i < NCH; i++) begin
                rsh_r[i] <= '0;
                rword_r[i] <= '0;
                rcnt_r[i] <= '0;
            end
        end else if (ce_in) begin
            for (int i = 0; i < NCH; i++) begin
                rsh_r[i] <= {rxs[i], rsh_r[i][WORD_W-1:1]};
                if (align_on && {rxs[i], rsh_r[i][WORD_W-1:4]} == COMMA_PAT) begin
                    rcnt_r[i] <= BIT_COMMA;
                    locked_r[i] <= 1'b1;
                end else if (rcnt_r[i] == BIT_LAST) begin
                    rcnt_r[i] <= '0;
                    rword_r[i] <= {rxs[i], rsh_r[i][WORD_W-1:1]};
                end else begin
                    rcnt_r[i] <= rcnt_r[i] + 4'h1;
                end
                if (!align_on) begin
                    locked_r[i] <= 1'b0;
                end
            end
        end
    end

    // error flag: a new mismatch beats a clear in the same cycle
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prbs_err_r <= '0;
            for (int i = 0; i < NCH; i++) begin
                chk_r[i] <= '0;
                fill_r[i] <= '0;
            end
        end else if (ce_in) begin
            for (int i = 0; i < NCH; i++) begin
                if (prbs_on) begin
                    chk_r[i] <= {chk_r[i][5:0], rxs[i]};
                    if (fill_r[i] != PRBS_FILL) begin
                        fill_r[i] <= fill_r[i] + 3'h1;
                    end
                end else begin
                    fill_r[i] <= '0;
                end
                if (prbs_on && fill_r[i] == PRBS_FILL
                        && rxs[i] != (chk_r[i][6] ^ chk_r[i][5])) begin
                    prbs_err_r[i] <= 1'b1;
                end else if (wr_stat && byteenable_in[0]
                        && writedata_in[STAT_PRBS_LSB + i]) begin
                    prbs_err_r[i] <= 1'b0;
                end
            end
        end
    end

    //--------------------------------------------------------
    // transmit steering and serialiser
    //--------------------------------------------------------
    logic [3:0] tcnt_r;
    logic [WORD_W-1:0] tsh_r [NCH];
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tcnt_r <= '0;
        end else if (ce_in) begin
            tcnt_r <= (tcnt_r == BIT_LAST) ? 4'h0 : tcnt_r + 4'h1;
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_serial_out <= '0;
            for (int i = 0; i < NCH; i++) begin
                tsh_r[i] <= '0;
            end
        end else if (ce_in) begin
            for (int i = 0; i < NCH; i++) begin
                logic [WORD_W-1:0] w;
                w = xchg_eff[i] ? par_r[i ^ 1] : par_r[i];
                if (pcs_eff[i] && !w[4]) begin
                    w = IDLE_WORD;
                end
                if (relay_eff[i]) begin
                    w = rword_r[i ^ 1];
                end
                if (tcnt_r == '0) begin
                    tsh_r[i] <= {1'b0, w[WORD_W-1:1]};
                end else begin
                    tsh_r[i] <= {1'b0, tsh_r[i][WORD_W-1:1]};
                end
                if (prbs_on) begin
                    tx_serial_out[i] <= gen_bit;
                end else if (relay_eff[i] && !rc_eff[i]) begin
                    tx_serial_out[i] <= rxs[i ^ 1];
                end else begin
                    tx_serial_out[i] <= (tcnt_r == '0) ? w[0] : tsh_r[i][0];
                end
            end
        end
    end

    //--------------------------------------------------------
    // receive parallel port
    //--------------------------------------------------------
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rx_clk_out <= '0;
            rx_nibble_bus_out <= '0;
        end else if (ce_in) begin
            for (int i = 0; i < NCH; i++) begin
                logic hi;
                hi = rc_eff[i] ? ref_s : (rcnt_r[i] < BIT_HALF);
                rx_clk_out[i] <= hi;
                rx_nibble_bus_out[i*NIB_W +: NIB_W] <= hi
                    ? rword_r[i][NIB_W-1:0]
                    : rword_r[i][WORD_W-1:NIB_W];
            end
        end
    end
endmodule // channel_mode_steering
`default_nettype wire

// >>> channel_mode_steering_pkg.sv
`default_nettype none
package channel_mode_steering_pkg;
    localparam int NCH = 6;
    localparam int NIB_W = 5;
    localparam int WORD_W = 10;
    // register byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam logic [31:0] CTRL_RST = 32'h0000_0007;
    // control fields
    localparam int CTRL_PCS_BIT = 0;
    localparam int CTRL_RC_BIT = 1;
    localparam int CTRL_COMMA_BIT = 2;
    localparam int CTRL_SGMII_BIT = 3;
    localparam int CTRL_XCHG_LSB = 8;
    localparam int CTRL_RELAY_LSB = 16;
    localparam int CTRL_PCSDIS_LSB = 24;
    // status fields
    localparam int STAT_PRBS_LSB = 0;
    localparam int STAT_LOCK_LSB = 8;
    localparam int STAT_RC_LSB = 16;
    localparam int STAT_PCS_LSB = 24;
    // first seven comma bits, bit 0 received first
    localparam logic [6:0] COMMA_PAT = 7'h7c;
    localparam logic [6:0] PRBS_SEED = 7'h7f;
    localparam logic [2:0] PRBS_FILL = 3'h7;
    localparam logic [9:0] IDLE_WORD = 10'h17c;
    localparam logic [3:0] BIT_LAST = 4'h9;
    localparam logic [3:0] BIT_COMMA = 4'h7;
    localparam logic [3:0] BIT_HALF = 4'h5;
    localparam logic [1:0] SGMII_CAPTURE = 2'h3;
    localparam int LINK_PERIOD_NS = 160;

    typedef struct packed {
        logic prbs_test_enable_pin;
        logic comma_align_enable;
        logic port_exchange_pin;
        logic relay_to_ace_pin;
        logic relay_to_bdf_pin;
        logic rate_comp_enable;
        logic pcs_select_pin;
        logic serial_gmii_pin;
    } pins_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;
endpackage
`default_nettype wire

// >>> channel_mode_steering_props.sv
`timescale 1ns/1ps
`default_nettype none
module channel_mode_steering_props
    import channel_mode_steering_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic [3:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    input wire logic [31:0] readdata_out,
    input wire logic waitrequest_out,
    input wire pins_t pins_in,
    input wire logic [NCH-1:0] rx_serial_in,
    input wire logic [NCH-1:0] tx_serial_out,
    input wire logic [NCH-1:0] rx_clk_out,
    input wire logic sgmii_mode_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    //----------------------------------------
    // mode age
    //----------------------------------------
    // pins pass a two-flop sync, so a mode only counts once settled
    logic [4:0] prbs_cnt_r, ace_cnt_r, bdf_cnt_r, rclk_cnt_r;
    wire logic quiet = !pins_in.prbs_test_enable_pin && !pins_in.rate_comp_enable;
    wire logic [2:0] tx_even = {tx_serial_out[4], tx_serial_out[2], tx_serial_out[0]};
    wire logic [2:0] tx_odd = {tx_serial_out[5], tx_serial_out[3], tx_serial_out[1]};
    wire logic [2:0] rx_even = {rx_serial_in[4], rx_serial_in[2], rx_serial_in[0]};
    wire logic [2:0] rx_odd = {rx_serial_in[5], rx_serial_in[3], rx_serial_in[1]};
    function automatic logic [4:0] age(input logic [4:0] c, input logic on);
        return on ? ((c == 5'h1f) ? c : c + 5'h01) : 5'h00;
    endfunction
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prbs_cnt_r <= 5'h00;
            ace_cnt_r <= 5'h00;
            bdf_cnt_r <= 5'h00;
            rclk_cnt_r <= 5'h00;
        end else begin
            prbs_cnt_r <= age(prbs_cnt_r, pins_in.prbs_test_enable_pin);
            ace_cnt_r <= age(ace_cnt_r, quiet && pins_in.relay_to_ace_pin);
            bdf_cnt_r <= age(bdf_cnt_r, quiet && pins_in.relay_to_bdf_pin);
            rclk_cnt_r <= age(rclk_cnt_r, !pins_in.rate_comp_enable
                && !pins_in.comma_align_enable);
        end
    end
    //----------------------------------------
    // properties
    //----------------------------------------
    ack_one_cycle_a: assert property (!waitrequest_out |=> waitrequest_out)
        else $error("waitrequest low for more than one cycle");
    bus_answer_a: assert property ($rose(read_in) || $rose(write_in) |->
        ##[0:3] !waitrequest_out) else $error("bus request never answered");
    unmapped_zero_a: assert property (read_in && !waitrequest_out
        && address_in != ADDR_CTRL && address_in != ADDR_STAT |-> readdata_out == 32'h0)
        else $error("unmapped read not zero");
    sgmii_write_a: assert property (write_in && !waitrequest_out
        && address_in == ADDR_CTRL && byteenable_in[0]
        |-> ##2 sgmii_mode_out == $past(writedata_in[CTRL_SGMII_BIT], 2))
        else $error("sgmii output does not follow control write");
    prbs_poly_a: assert property (prbs_cnt_r >= 5'h14 |->
        (tx_serial_out ^ $past(tx_serial_out, 6) ^ $past(tx_serial_out, 7)) == 6'h00)
        else $error("transmit stream is not a 7-bit prbs");
    relay_ace_a: assert property (ace_cnt_r >= 5'h08 |->
        tx_even == $past(rx_odd, 3)) else $error("a/c/e relay data wrong");
    relay_bdf_a: assert property (bdf_cnt_r >= 5'h08 |->
        tx_odd == $past(rx_even, 3)) else $error("b/d/f relay data wrong");
    rclk_half_a: assert property (rclk_cnt_r >= 5'h0c |->
        rx_clk_out == ~$past(rx_clk_out, 5)) else $error("recovered clock not 5/5");
    cover property (prbs_cnt_r == 5'h14);
    cover property (ace_cnt_r == 5'h08);
    cover property (bdf_cnt_r == 5'h08);
endmodule // channel_mode_steering_props
bind channel_mode_steering channel_mode_steering_props props_u (.clk_sys_in, .sys_rst_in,
    .address_in, .read_in, .write_in, .writedata_in, .byteenable_in, .readdata_out,
    .waitrequest_out, .pins_in, .rx_serial_in, .tx_serial_out, .rx_clk_out, .sgmii_mode_out);
`default_nettype wire

// >>> mac_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
module mac_partner_model
    import channel_mode_steering_pkg::*;
(
    input wire logic send_in,
    input wire logic [NCH*WORD_W-1:0] words_in,
    output logic tx_clk_out,
    output logic [NCH*NIB_W-1:0] nib_out
);
    // clock stands still between frames; idle data toggles so no stale value passes
    initial begin
        tx_clk_out = 1'b0;
        nib_out = '0;
        #7;
        forever begin
            if (send_in) begin
                for (int i = 0; i < NCH; i++) nib_out[i*NIB_W +: NIB_W] = words_in[i*WORD_W +: NIB_W];
                #10 tx_clk_out = 1'b1;
                #65;
                for (int i = 0; i < NCH; i++) nib_out[i*NIB_W +: NIB_W] = words_in[i*WORD_W+NIB_W +: NIB_W];
                #5 tx_clk_out = 1'b0;
                #80;
            end else begin
                nib_out = ~nib_out;
                #20;
            end
        end
    end
endmodule // mac_partner_model
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb
    import channel_mode_steering_pkg::*;
;
    logic clk_sys_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [3:0] address_in = 4'h0;
    logic read_in = 1'b0;
    logic write_in = 1'b0;
    logic [31:0] writedata_in = 32'h0;
    logic [3:0] byteenable_in = 4'hf;
    logic ref_clock_in = 1'b0;
    // rate comp, pcs select and sgmii pins start high
    pins_t pins_in = 8'h07;
    logic [NCH-1:0] rx_serial_in = '0;
    logic [31:0] readdata_out;
    logic waitrequest_out, tx_clk_in, sgmii_mode_out;
    logic [NCH*NIB_W-1:0] tx_nibble_bus_in, rx_nibble_bus_out;
    logic [NCH-1:0] tx_serial_out, rx_clk_out;
    logic send = 1'b0;
    logic [NCH*WORD_W-1:0] words = '0;
    logic [1:0] rx_mode = 2'h0;
    logic inv = 1'b0;
    logic [3:0] cbit = 4'h0;
    logic [NIB_W-1:0] nib, nexp;
    logic [31:0] ctrl = CTRL_RST;
    logic [31:0] exp_q[$], msk_q[$];
    int n_mismatch = 0;
    int cmp_count = 0;
    always #10 clk_sys_in = ~clk_sys_in;
    always #83 ref_clock_in = ~ref_clock_in;
    channel_mode_steering dut_u (.clk_sys_in, .sys_rst_in, .ce_in(1'b1), .address_in, .read_in,
        .write_in, .writedata_in, .byteenable_in, .readdata_out, .waitrequest_out, .ref_clock_in,
        .tx_clk_in, .pins_in, .tx_nibble_bus_in, .rx_serial_in, .tx_serial_out,
        .rx_nibble_bus_out, .rx_clk_out, .sgmii_mode_out);
    mac_partner_model pm_u (.send_in(send), .words_in(words), .tx_clk_out(tx_clk_in),
        .nib_out(tx_nibble_bus_in));
    //----------------------------------------
    // line side: random, loopback or commas
    //----------------------------------------
    always @(posedge clk_sys_in) begin
        case (rx_mode)
            2'h0: rx_serial_in <= NCH'($urandom());
            2'h1: rx_serial_in <= tx_serial_out ^ {NCH{inv}};
            default: begin
                rx_serial_in <= {NCH{IDLE_WORD[cbit]}};
                cbit <= (cbit == BIT_LAST) ? 4'h0 : cbit + 4'h1;
            end
        endcase
    end
    always @(posedge clk_sys_in) begin
        if (read_in === 1'b1 && waitrequest_out === 1'b0 && exp_q.size() > 0) begin
            `CHK("readdata", exp_q[0] & msk_q[0], readdata_out & msk_q[0])
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end
    task automatic results();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [31:0] m);
        int k;
        k = 0;
        @(posedge clk_sys_in);
        address_in <= a;
        writedata_in <= d;
        write_in <= wr;
        read_in <= !wr;
        if (!wr) begin
            exp_q.push_back(d);
            msk_q.push_back(m);
        end
        do begin
            @(posedge clk_sys_in);
            k++;
        end while (waitrequest_out !== 1'b0 && k < 50);
        if (k >= 50) begin
            n_mismatch++;
            results();
        end
        read_in <= 1'b0;
        write_in <= 1'b0;
    endtask
    task automatic wrc(input logic [31:0] v);
        ctrl = v;
        bus(1'b1, ADDR_CTRL, v, 32'h0);
    endtask
    function automatic logic [31:0] stat_exp(input pins_t p, input logic [31:0] c);
        logic [5:0] pcs;
        pcs = (p.pcs_select_pin && c[CTRL_PCS_BIT]) ? ~c[CTRL_PCSDIS_LSB +: 6] : 6'h00;
        return {2'h0, pcs, 2'h0, (p.rate_comp_enable && c[CTRL_RC_BIT]) ? pcs : 6'h00, 16'h0};
    endfunction
    // a rotation match: the load phase of the serialiser is free running
    task automatic chk_tx(input logic [NCH-1:0] swap);
        logic [NCH-1:0] b[10];
        logic [WORD_W-1:0] w, e;
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_sys_in);
            b[i] = tx_serial_out;
        end
        for (int c = 0; c < NCH; c++) begin
            e = words[(c ^ swap[c]) * WORD_W +: WORD_W];
            // pcs mode: a word without the enable bit goes out as idle
            if (pins_in.pcs_select_pin && !e[4]) e = IDLE_WORD;
            for (int i = 0; i < 10; i++) w[i] = b[i][c];
            for (int r = 0; r < 10 && w !== e; r++) w = {w[0], w[9:1]};
            `CHK("serial word", e, w)
        end
    endtask
    //----------------------------------------
    // main sequence
    //----------------------------------------
    initial begin
        void'($urandom(82072));
        repeat (3) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        repeat (6) @(posedge clk_sys_in);
        `CHK("sgmii_mode_out", 1'b1, sgmii_mode_out)
        bus(1'b0, ADDR_CTRL, CTRL_RST | 32'h8, 32'hffff_ffff);
        bus(1'b0, 4'h8, 32'h0, 32'hffff_ffff);
        pins_in.serial_gmii_pin <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        repeat (6) @(posedge clk_sys_in);
        `CHK("sgmii_mode_out", 1'b0, sgmii_mode_out)
        wrc(CTRL_RST | 32'h8);
        for (int k = 0; k < 6; k++) begin
            pins_in.pcs_select_pin <= k[0];
            pins_in.rate_comp_enable <= k[1] | k[2];
            wrc(($urandom() & 32'h3f00_0003) | 32'h4);
            repeat (8) @(posedge clk_sys_in);
            bus(1'b0, ADDR_STAT, stat_exp(pins_in, ctrl), 32'h3f3f_0000);
        end
        wrc(CTRL_RST);
        pins_in.rate_comp_enable <= 1'b0;
        pins_in.relay_to_bdf_pin <= 1'b1;
        repeat (40) @(posedge clk_sys_in);
        pins_in.relay_to_bdf_pin <= 1'b0;
        pins_in.relay_to_ace_pin <= 1'b1;
        repeat (40) @(posedge clk_sys_in);
        pins_in.relay_to_ace_pin <= 1'b0;
        pins_in.pcs_select_pin <= 1'b0;
        words <= (NCH*WORD_W)'({$urandom(), $urandom()});
        send <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            pins_in.port_exchange_pin <= (k == 1);
            pins_in.pcs_select_pin <= (k == 3);
            wrc(CTRL_RST | ((k == 2) ? 32'h100 : 32'h0));
            repeat (40) @(posedge clk_sys_in);
            chk_tx((k == 1) ? 6'h3f : (k == 2) ? 6'h03 : 6'h00);
        end
        pins_in.port_exchange_pin <= 1'b0;
        pins_in.prbs_test_enable_pin <= 1'b1;
        rx_mode <= 2'h1;
        for (int k = 0; k < 3; k++) begin
            inv <= (k == 1);
            repeat (30) @(posedge clk_sys_in);
            if (k != 1) begin
                bus(1'b1, ADDR_STAT, 32'h3f, 32'h0);
                repeat (4) @(posedge clk_sys_in);
            end
            bus(1'b0, ADDR_STAT, (k == 1) ? 32'h3f : 32'h0, 32'h3f);
        end
        pins_in.prbs_test_enable_pin <= 1'b0;
        rx_mode <= 2'h2;
        for (int k = 0; k < 3; k++) begin
            pins_in.comma_align_enable <= (k != 0);
            wrc((k == 1) ? 32'h3 : CTRL_RST);
            repeat (40) @(posedge clk_sys_in);
            bus(1'b0, ADDR_STAT, (k == 2) ? 32'h3f00 : 32'h0, 32'h3f00);
        end
        // locked idle word: low half stands while the rx clock is high
        repeat (10) begin
            @(posedge clk_sys_in);
            for (int c = 0; c < NCH; c++) begin
                nib = rx_nibble_bus_out[c*NIB_W +: NIB_W];
                nexp = rx_clk_out[c] ? IDLE_WORD[4:0] : IDLE_WORD[9:5];
                `CHK("rx nibble", nexp, nib)
            end
        end
        results();
    end
    initial begin
        #1000000;
        n_mismatch++;
        results();
    end
endmodule // tb
`default_nettype wire
